//--- bench/host_cpu_model.sv
// Behavioural host controller on the multiplexed bus
module host_cpu_model (
  input  wire logic        i_clock,
  input  wire logic [15:0] i_bus,
  input  wire logic        i_ready_n,
  input  wire logic        i_ready_raw_n,
  output logic      [15:0] o_ad,
  output logic             o_ale = 0,
  output logic             o_ws = 0,
  output logic             o_cs_n = 1,
  output logic             o_rd_n = 1,
  output logic             o_wr_n = 1
);
  logic [15:0] ad_reg = 16'h0000;
  logic        drive = 0;
  // A released bus shows the inverse of its last value, never a stale match
  assign o_ad = drive ? ad_reg : ~ad_reg;
  task automatic cyc(input logic w, input logic [15:0] a, d, output logic [15:0] q, output logic ok);
    int n;
    @(posedge i_clock) #1;
    ad_reg = {a[15:1], 1'b0};
    drive = 1;
    o_ws = a[1];
    o_ale = 1;
    repeat (2) @(posedge i_clock);
    #1 o_ale = 0;
    repeat (4) @(posedge i_clock);
    #1 ad_reg = d;
    drive = w;
    {o_cs_n, o_rd_n, o_wr_n} = {1'b0, w, !w};
    for (n = 0; n < 20 && i_ready_n !== 1'b0; n++) @(posedge i_clock) #1;
    ok = n < 20;
    // Ready seen after an edge: hold the strobe to the next edge and take the data there
    @(posedge i_clock);
    q = i_bus;
    #1 drive = 0;
    {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
    for (n = 0; n < 20 && i_ready_raw_n !== 1'b1; n++) @(posedge i_clock) #1;
    ok = ok && n < 20;
  endtask
endmodule

//--- bench/hp_checker.sv
// Pin-level assertions for the host port
module hp_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_chip_select_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_irq_event,
  input wire logic o_ad_oe_n,
  input wire logic o_cycle_ready_n,
  input wire logic o_cycle_ready_oe_n,
  input wire logic o_irq_request_n,
  input wire logic o_irq_request_oe_n,
  input wire logic o_cfg_write
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  irq_low_a: assert property (o_irq_request_n == 1'b0) else $error("irq high");
  irq_pull_a: assert property (i_irq_event |=> !o_irq_request_oe_n) else $error("irq");
  ready_float_a: assert property (o_cycle_ready_oe_n == i_chip_select_n) else $error("rdy oe");
  bus_free_a: assert property (i_chip_select_n || i_read_strobe_n |-> o_ad_oe_n) else $error("bus");
  idle_quiet_a: assert property (i_chip_select_n [*6] |-> !o_cfg_write && o_cycle_ready_n) else $error("cs");
  write_pulse_a: assert property (o_cfg_write |-> !o_cycle_ready_n ##1 !o_cfg_write) else $error("wr");
  write_ready_a: assert property ($fell(i_write_strobe_n) && !i_chip_select_n
    |-> ##[3:6] !o_cycle_ready_n) else $error("wr rdy");
  read_ready_a: assert property ($fell(i_read_strobe_n) && !i_chip_select_n
    |-> ##[3:6] !o_cycle_ready_n && !o_ad_oe_n) else $error("rd rdy");
endmodule
bind mux_bus_host_port hp_checker i_chk (.*);

//--- bench/mux_bus_host_port_tb.sv
// Self-checking bench for the multiplexed host port
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED at %0t: value mismatch", $time); end end
module mux_bus_host_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clock = 0;
  logic        i_rst = 1;
  logic        i_irq_event = 0;
  logic [15:0] host_ad, o_ad, o_cfg_data, q;
  logic [5:0]  o_cfg_addr;
  logic        i_addr_latch, i_word_select_pin, i_chip_select_n, i_read_strobe_n, i_write_strobe_n, ok;
  logic        o_ad_oe_n, o_cycle_ready_n, o_cycle_ready_oe_n, o_irq_request_n, o_irq_request_oe_n;
  logic        o_big_endian, o_cfg_write;
  wire  [15:0] i_ad = o_ad_oe_n ? host_ad : o_ad;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [15:0] cfg_seen_data = 16'h0000;
  logic [5:0]  cfg_seen_addr = 6'h00;
  initial forever #2.5 i_clock = ~i_clock;
  // Latch each configuration write away from the edge that launches it
  always @(negedge i_clock) begin
    if (o_cfg_write === 1'b1) begin
      cfg_seen_data = o_cfg_data;
      cfg_seen_addr = o_cfg_addr;
    end
  end
  mux_bus_host_port i_dut (
    .i_clock            (i_clock),
    .i_rst              (i_rst),
    .i_ad               (i_ad),
    .o_ad               (o_ad),
    .o_ad_oe_n          (o_ad_oe_n),
    .i_addr_latch       (i_addr_latch),
    .i_word_select_pin  (i_word_select_pin),
    .i_chip_select_n    (i_chip_select_n),
    .i_read_strobe_n    (i_read_strobe_n),
    .i_write_strobe_n   (i_write_strobe_n),
    .o_cycle_ready_n    (o_cycle_ready_n),
    .o_cycle_ready_oe_n (o_cycle_ready_oe_n),
    .o_irq_request_n    (o_irq_request_n),
    .o_irq_request_oe_n (o_irq_request_oe_n),
    .i_irq_event        (i_irq_event),
    .o_big_endian       (o_big_endian),
    .o_cfg_data         (o_cfg_data),
    .o_cfg_addr         (o_cfg_addr),
    .o_cfg_write        (o_cfg_write)
  );
  host_cpu_model i_host (.i_clock(i_clock), .i_bus(i_ad), .i_ready_n(o_cycle_ready_oe_n | o_cycle_ready_n),
    .i_ready_raw_n(o_cycle_ready_n), .o_ad(host_ad), .o_ale(i_addr_latch), .o_ws(i_word_select_pin),
    .o_cs_n(i_chip_select_n), .o_rd_n(i_read_strobe_n), .o_wr_n(i_write_strobe_n));
  task automatic give_verdict;
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d);
    i_host.cyc(w, a, d, q, ok);
    if (ok !== 1'b1) begin fail_count++; give_verdict; end
  endtask
  task automatic t_store;
    acc(1, 16'h0002, 16'h1234);
    `CHK(cfg_seen_data, 16'h1234);
    `CHK(cfg_seen_addr, 6'h01);
    acc(1, 16'h007E, 16'hBEEF);
    `CHK(cfg_seen_addr, 6'h3F);
    acc(0, 16'h0002, 0); `CHK(q, 16'h1234);
    acc(0, 16'h007E, 0); `CHK(q, 16'hBEEF);
  endtask
  task automatic t_endian;
    `CHK(o_big_endian, 1'b1);
    acc(1, 16'h0000, 16'h0000); `CHK(o_big_endian, 1'b0);
    acc(0, 16'h0002, 0); `CHK(q, 16'h3412);
    acc(1, 16'h0004, 16'hA1B2);
    `CHK(cfg_seen_data, 16'hB2A1);
    acc(0, 16'h0004, 0);
    `CHK(q, 16'hA1B2);
    acc(1, 16'h0000, 16'h8000);
    `CHK(o_big_endian, 1'b0);
    acc(1, 16'h0000, 16'h0100);
    `CHK(o_big_endian, 1'b1);
    acc(1, 16'h0000, 16'h0101); `CHK(o_big_endian, 1'b1);
  endtask
  task automatic t_irq;
    @(posedge i_clock) #1 i_irq_event = 1;
    repeat (3) @(posedge i_clock); `CHK(o_irq_request_oe_n, 1'b0);
    #1 i_irq_event = 0;
    repeat (3) @(posedge i_clock); `CHK(o_irq_request_oe_n, 1'b1);
  endtask
  task automatic t_reset;
    acc(1, 16'h0000, 16'h0000);
    `CHK(o_big_endian, 1'b0);
    @(posedge i_clock) #1 i_rst = 1;
    repeat (2) @(posedge i_clock);
    #1 i_rst = 0;
    `CHK(o_big_endian, 1'b1);
    `CHK(o_cycle_ready_n, 1'b1);
    acc(0, 16'h0002, 0);
    `CHK(q, 16'h1234);
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    #1 i_rst = 0;
    `CHK(o_ad_oe_n, 1'b1);
    t_store;
    t_endian;
    t_irq;
    t_reset;
    give_verdict;
  end
endmodule

//--- hdl/mux_bus_host_port.v
// Multiplexed address/data host port with register store for configuration
`include "mux_bus_host_port_consts.vh"
module mux_bus_host_port #(
  parameter WORD_ADDR_W = 6
) (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire [15:0] i_ad,
  output reg  [15:0] o_ad,
  output wire        o_ad_oe_n,
  input  wire        i_addr_latch,
  input  wire        i_word_select_pin,
  input  wire        i_chip_select_n,
  input  wire        i_read_strobe_n,
  input  wire        i_write_strobe_n,
  output wire        o_cycle_ready_n,
  output wire        o_cycle_ready_oe_n,
  output wire        o_irq_request_n,
  output wire        o_irq_request_oe_n,
  input  wire        i_irq_event,
  output wire        o_big_endian,
  output reg  [15:0] o_cfg_data,
  output reg  [WORD_ADDR_W-1:0] o_cfg_addr,
  output reg         o_cfg_write
);
  localparam DEPTH   = 1 << WORD_ADDR_W;
  localparam S_IDLE  = 4'h1;
  localparam S_READ  = 4'h2;
  localparam S_WRITE = 4'h4;
  localparam S_DONE  = 4'h8;

  wire [15:0] ad_s;
  wire [4:0]  ctl_s;
  // Data is sampled two cycles late, so ready waits for the bus to settle
  pin_sync #(.WIDTH(16), .RST_VAL(16'h0000)) u_ad_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_ad),
    .o_sync  (ad_s)
  );
  pin_sync #(.WIDTH(5), .RST_VAL(`HP_CTL_IDLE)) u_ctl_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_addr_latch, i_chip_select_n, i_read_strobe_n, i_write_strobe_n, i_word_select_pin}),
    .o_sync  (ctl_s)
  );
  wire ale_s = ctl_s[4];
  wire cs_s  = ~ctl_s[3];
  wire rd_s  = ~ctl_s[2];
  wire wr_s  = ~ctl_s[1];
  wire ws_s  = ctl_s[0];

  function [15:0] swap_order;
    input [15:0] w;
    input        big;
    begin
      swap_order = big ? w : {w[7:0], w[15:8]};
    end
  endfunction

  reg [15:0] mem [0:DEPTH-1];
  reg [WORD_ADDR_W-1:0] addr_reg;
  reg [3:0]  state_reg;
  reg        ale_d_reg;
  reg        big_endian_reg;
  reg        irq_reg;
  reg        drive_reg;
  wire [WORD_ADDR_W-1:0] waddr = addr_reg;

  // Word index from the latched bus: bit 0 never takes part in decoding
  function [WORD_ADDR_W-1:0] word_index;
    input [15:0] bus;
    input        bit1;
    begin
      word_index = {bus[WORD_ADDR_W:2], bit1};
    end
  endfunction

  // Word 0 holds the byte-order control
  function is_order_word;
    input [WORD_ADDR_W-1:0] idx;
    begin
      is_order_word = (idx == {WORD_ADDR_W{1'b0}});
    end
  endfunction

  // Address bit 1 comes straight from its own pin, synchronised like the bus
  always @(posedge i_clock) begin
    if (i_rst) begin
      addr_reg  <= {WORD_ADDR_W{1'b0}};
      ale_d_reg <= 1'b0;
    end else begin
      ale_d_reg <= ale_s;
      // Falling latch strobe marks the end of the address phase
      if (ale_d_reg && !ale_s) begin
        addr_reg <= word_index(ad_s, ws_s);
      end
    end
  end

  // Next-state and per-cycle controls of the bus cycle sequencer
  reg  [3:0]  state_next;
  reg         drive_next;
  reg         big_endian_next;
  reg         cfg_write_next;
  reg         read_load;
  // Little-endian hosts present the flag in the upper byte lane
  wire        order_bit = ad_s[`HP_ENDIAN_BIT] | ad_s[`HP_ENDIAN_BIT_SWAP];
  wire [15:0] wr_word   = swap_order(ad_s, big_endian_reg);

  always @* begin
    state_next      = state_reg;
    drive_next      = drive_reg;
    big_endian_next = big_endian_reg;
    cfg_write_next  = 1'b0;
    read_load       = 1'b0;
    case (state_reg)
      S_IDLE: begin
        drive_next = 1'b0;
        if (cs_s && rd_s) begin
          state_next = S_READ;
        end else if (cs_s && wr_s) begin
          state_next = S_WRITE;
        end
      end
      S_READ: begin
        read_load  = 1'b1;
        drive_next = 1'b1;
        state_next = S_DONE;
      end
      S_WRITE: begin
        cfg_write_next = 1'b1;
        // A write to word 0 also lands in the store, swapped by the old byte order, so a write that changes the order reads back byte-swapped
        if (is_order_word(waddr)) begin
          big_endian_next = order_bit;
        end
        state_next = S_DONE;
      end
      S_DONE: begin
        // Hold ready until the host lets go of the strobe
        if (!(cs_s && (rd_s || wr_s))) begin
          state_next = S_IDLE;
          drive_next = 1'b0;
        end
      end
      default: begin
        // Illegal codes fall back to idle with the bus released
        state_next = S_IDLE;
        drive_next = 1'b0;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      state_reg      <= S_IDLE;
      big_endian_reg <= `HP_BIG_ENDIAN_RST;
      drive_reg      <= 1'b0;
      o_cfg_write    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      big_endian_reg <= big_endian_next;
      drive_reg      <= drive_next;
      o_cfg_write    <= cfg_write_next;
    end
  end

  // Read data is latched once per cycle and holds until the next read
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_ad       <= 16'h0000;
      o_cfg_data <= 16'h0000;
      o_cfg_addr <= {WORD_ADDR_W{1'b0}};
    end else begin
      if (read_load) begin
        o_ad <= swap_order(mem[waddr], big_endian_reg);
      end
      if (cfg_write_next) begin
        o_cfg_data <= wr_word;
        o_cfg_addr <= waddr;
      end
    end
  end

  // Store keeps no reset value: a hard reset must not wipe the loaded coefficients
  always @(posedge i_clock) begin
    if (!i_rst && cfg_write_next) begin
      mem[waddr] <= wr_word;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      // Registered so the open-drain pull changes only on clock edges
      irq_reg <= i_irq_event;
    end
  end

  // Bus released unless chip select and read are both still present
  // Raw pins here let the bus go at once; synchronised pins would release it two clocks late
  assign o_ad_oe_n          = ~(drive_reg & ~i_chip_select_n & ~i_read_strobe_n);
  assign o_cycle_ready_n    = ~(state_reg == S_DONE);
  assign o_cycle_ready_oe_n = i_chip_select_n;
  assign o_irq_request_n    = 1'b0;
  assign o_irq_request_oe_n = ~irq_reg;
  assign o_big_endian       = big_endian_reg;
endmodule

//--- hdl/mux_bus_host_port_consts.vh
// Constants for the multiplexed host bus port
`ifndef MUX_BUS_HOST_PORT_CONSTS_VH
`define MUX_BUS_HOST_PORT_CONSTS_VH
`define HP_DATA_W          16
`define HP_ADDR_W          16
`define HP_SYNC_STAGES     2
`define HP_BIG_ENDIAN_RST  1'b1
`define HP_ENDIAN_BIT      0
`define HP_ENDIAN_BIT_SWAP 8
`define HP_CTL_IDLE        5'h0E
`define HP_CLOCK_MHZ       200
`define HP_ACC_TIME_NS     900
`define HP_ACC_CYCLES      ((`HP_ACC_TIME_NS * `HP_CLOCK_MHZ) / 1000)
`endif

//--- hdl/pin_sync.v
// Two-stage synchroniser for a group of asynchronous pins
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             i_clock,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  // First stage feeds only the second stage
  always @(posedge i_clock) begin
    if (i_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule
